/* File: idc_decoder.sv */
// What this block does
// - Store opcode copies the working register into file register f, one cycle, no flags.
// - Option-load opcode copies the working register into the option register, one cycle.
// - Option register is also read and written as an ordinary file register.
// - Interrupt return pops the stack and loads the popped entry into the PC.
// - Interrupt return sets the global interrupt enable, bit 7 of interrupt control.
// - Interrupt return takes two cycles; the other three instructions take one.
`timescale 1ns/1ps
module idc_decoder #(
	parameter int PC_W = 11,
	parameter int STACK_DEPTH = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Instruction stream from program memory
	input wire logic instr_valid,
	input wire logic [idc_pkg::INSTR_W-1:0] instr_word,
	output logic instr_ready,
	// Working register load from the rest of the core
	input wire logic acc_load,
	input wire logic [idc_pkg::DATA_W-1:0] acc_load_data,
	output logic [idc_pkg::DATA_W-1:0] acc,
	// File register bus
	input wire idc_pkg::idc_file_wr_t ext_file_wr,
	input wire logic [idc_pkg::FADDR_W-1:0] file_rd_addr,
	output logic [idc_pkg::DATA_W-1:0] file_rd_data,
	output idc_pkg::idc_file_wr_t file_wr,
	// Program counter, stack and interrupts
	input wire logic stack_push,
	input wire logic [PC_W-1:0] stack_push_addr,
	input wire logic irq_en_clear,
	output logic [PC_W-1:0] pc,
	output logic [idc_pkg::DATA_W-1:0] option_reg,
	output logic [idc_pkg::DATA_W-1:0] irq_control_register,
	output logic global_irq_enable
);
	import idc_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH);

	// Pointer wraps circularly, so depth must fill the index range
	if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH || PC_W < 2) begin : g_bad_params
		$error("idc_decoder: STACK_DEPTH must be a power of two >= 2, PC_W >= 2");
	end

	idc_state_t state_r;
	logic ready_r;
	logic [PC_W-1:0] pc_r;
	logic [DATA_W-1:0] acc_r;
	logic [DATA_W-1:0] option_r;
	logic [DATA_W-1:0] irqctl_r;
	logic [DATA_W-1:0] rd_data_r;
	idc_file_wr_t file_wr_r;
	logic [SP_W-1:0] sp_r;
	logic [PC_W-1:0] stack_r [STACK_DEPTH];

	logic accept;
	logic is_store;
	logic is_idle;
	logic is_opt_load;
	logic is_irq_ret;
	logic do_pop;
	logic [SP_W-1:0] top_idx;
	logic [SP_W-1:0] wr_idx;
	logic [PC_W-1:0] top_of_stack;
	idc_file_wr_t fw;

	assign accept = instr_valid && ready_r;
	assign is_store = (instr_word & OP_STORE_MASK) == OP_STORE_VAL;
	assign is_idle = (instr_word & OP_IDLE_MASK) == OP_IDLE_VAL;
	assign is_opt_load = instr_word == OP_OPT_LOAD;
	assign is_irq_ret = instr_word == OP_IRQ_RET;
	assign do_pop = accept && is_irq_ret;
	assign top_idx = sp_r - SP_W'(1);
	assign top_of_stack = stack_r[top_idx];
	// Push during a pop overwrites the popped slot
	assign wr_idx = do_pop ? top_idx : sp_r;

	// Instruction-driven file write beats the external one
	always_comb begin
		fw = ext_file_wr;
		if (accept && is_store) begin
			fw.we = 1'b1;
			fw.addr = instr_word[FADDR_W-1:0];
			fw.data = acc_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= ST_RUN;
			ready_r <= 1'b1;
		end else if (state_r == ST_IRET2) begin
			state_r <= ST_RUN;
			ready_r <= 1'b1;
		end else if (do_pop) begin
			state_r <= ST_IRET2;
			ready_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pc_r <= '0;
		end else if (do_pop) begin
			pc_r <= top_of_stack;
		end else if (accept) begin
			pc_r <= pc_r + PC_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sp_r <= '0;
		end else if (do_pop && !stack_push) begin
			sp_r <= top_idx;
		end else if (stack_push && !do_pop) begin
			sp_r <= sp_r + SP_W'(1);
		end
	end

	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				stack_r[i] <= '0;
			end else if (stack_push && wr_idx == SP_W'(i)) begin
				stack_r[i] <= stack_push_addr;
			end
		end
	end

	// Working register is never written by these four opcodes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			acc_r <= ACC_RST;
		end else if (acc_load) begin
			acc_r <= acc_load_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			file_wr_r <= '0;
		end else begin
			file_wr_r <= fw;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			option_r <= OPTION_RST;
		end else if (accept && is_opt_load) begin
			option_r <= acc_r;
		end else if (fw.we && fw.addr == OPTION_FADDR) begin
			option_r <= fw.data;
		end
	end

	// set by return beats any clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irqctl_r <= IRQCTL_RST;
		end else begin
			if (fw.we && fw.addr == IRQCTL_FADDR) begin
				irqctl_r <= fw.data;
			end else if (irq_en_clear) begin
				irqctl_r[IRQ_EN_BIT] <= 1'b0;
			end
			if (do_pop) begin
				irqctl_r[IRQ_EN_BIT] <= 1'b1;
			end
		end
	end

	// read back; unheld addresses read zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_data_r <= '0;
		end else if (file_rd_addr == OPTION_FADDR) begin
			rd_data_r <= option_r;
		end else if (file_rd_addr == IRQCTL_FADDR) begin
			rd_data_r <= irqctl_r;
		end else begin
			rd_data_r <= '0;
		end
	end

	assign instr_ready = ready_r;
	assign pc = pc_r;
	assign acc = acc_r;
	assign file_wr = file_wr_r;
	assign file_rd_data = rd_data_r;
	assign option_reg = option_r;
	assign irq_control_register = irqctl_r;
	assign global_irq_enable = irqctl_r[IRQ_EN_BIT];

	AST_STORE_WRITES_F: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		accept && is_store |=> file_wr_r.we && file_wr_r.data == $past(acc_r)
			&& file_wr_r.addr == $past(instr_word[FADDR_W-1:0])
			&& pc_r == $past(pc_r) + PC_W'(1) && ready_r)
		else $error("store did not write the file register in one cycle");

	AST_OPT_LOAD: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		accept && is_opt_load |=> option_r == $past(acc_r) && ready_r)
		else $error("option load did not copy the working register");

	AST_OPT_ADDRESSABLE: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		fw.we && fw.addr == OPTION_FADDR && !(accept && is_opt_load)
			##1 file_rd_addr == OPTION_FADDR |=> file_rd_data == $past(fw.data, 2))
		else $error("option register not reachable as a file register");

	AST_RET_PC: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		do_pop && !stack_push |=> pc_r == $past(top_of_stack) && sp_r == $past(sp_r) - SP_W'(1))
		else $error("return did not load the popped entry");

	AST_RET_IRQ_EN: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		do_pop |=> global_irq_enable && irqctl_r[IRQ_EN_BIT])
		else $error("return did not set the global interrupt enable");

	AST_RET_TWO_CYCLES: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		do_pop |=> !instr_ready ##1 instr_ready)
		else $error("return did not take exactly two cycles");

	AST_IDLE_NOCHANGE: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		accept && is_idle && !acc_load && !stack_push && !irq_en_clear && !ext_file_wr.we
			|=> pc_r == $past(pc_r) + PC_W'(1) && $stable(acc_r) && $stable(option_r)
			&& $stable(irqctl_r) && $stable(sp_r) && !file_wr_r.we && ready_r)
		else $error("idle instruction changed state");
endmodule : idc_decoder

/* File: idc_pkg.sv */
package idc_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	// Opcode patterns: store and idle are value under mask, option load and return are exact words
	localparam logic [13:0] OP_STORE_MASK = 14'h3F80;
	localparam logic [13:0] OP_STORE_VAL = 14'h0080;
	localparam logic [13:0] OP_IDLE_MASK = 14'h3F9F;
	localparam logic [13:0] OP_IDLE_VAL = 14'h0000;
	localparam logic [13:0] OP_OPT_LOAD = 14'h0062;
	localparam logic [13:0] OP_IRQ_RET = 14'h0009;
	// File addresses of the two registers held here
	localparam logic [6:0] OPTION_FADDR = 7'h01;
	localparam logic [6:0] IRQCTL_FADDR = 7'h0B;
	localparam int IRQ_EN_BIT = 7;
	localparam logic [7:0] OPTION_RST = 8'hFF;
	localparam logic [7:0] IRQCTL_RST = 8'h00;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam int IRQ_RET_CYCLES = 2;

	typedef struct packed {
		logic we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} idc_file_wr_t;

	typedef enum logic {
		ST_RUN,
		ST_IRET2
	} idc_state_t;
endpackage : idc_pkg

/* File: idc_prog_mem.sv */
`timescale 1ns/1ps
module idc_prog_mem (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Instruction stream
	input wire logic instr_ready,
	output logic instr_valid,
	output logic [idc_pkg::INSTR_W-1:0] instr_word
);
	import idc_pkg::*;
	logic [INSTR_W-1:0] mem [0:63];
	logic tog_r;
	int idx;
	int len = 0;
	assign instr_valid = idx < len;
	// Idle bus toggles so a stale word is never mistaken for a fresh one
	assign instr_word = instr_valid ? mem[idx] : {7{tog_r, ~tog_r}};
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tog_r <= 1'b0;
			idx <= 0;
		end else begin
			tog_r <= ~tog_r;
			if (instr_valid && instr_ready) begin
				idx <= idx + 1;
			end
		end
	end
endmodule : idc_prog_mem

/* File: instr_decode_move_nop_interrupt_return_tb.sv */
`timescale 1ns/1ps
module instr_decode_move_nop_interrupt_return_tb;
	import idc_pkg::*;
	logic core_clk = 0, rst_n = 0, instr_valid, instr_ready, acc_load = 0;
	logic stack_push = 0, irq_en_clear = 0, irq_en;
	logic [13:0] instr_word;
	logic [7:0] acc_load_data = 0, acc, rd, opt, irq;
	logic [6:0] rd_addr = 0;
	logic [10:0] push_addr = 0, pc;
	idc_file_wr_t ext_wr = '0, fwr;
	int n_errors = 0, total_checks = 0, cyc = 0;
	int m_pc = 0, m_acc = 0, m_opt = OPTION_RST, m_irq = IRQCTL_RST;
	int stk[$];
	logic [31:0] seed = 6, r;
	always #5 core_clk = ~core_clk;
	idc_decoder dut_u (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .acc_load(acc_load),
		.acc_load_data(acc_load_data), .acc(acc), .ext_file_wr(ext_wr), .file_rd_addr(rd_addr),
		.file_rd_data(rd), .file_wr(fwr), .stack_push(stack_push), .stack_push_addr(push_addr),
		.irq_en_clear(irq_en_clear), .pc(pc), .option_reg(opt), .irq_control_register(irq),
		.global_irq_enable(irq_en));
	idc_prog_mem mem_u (.core_clk(core_clk), .rst_n(rst_n), .instr_ready(instr_ready),
		.instr_valid(instr_valid), .instr_word(instr_word));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task chk(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wrap_up;
		if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up();
		end
	end
	task run(logic [13:0] w);
		mem_u.mem[mem_u.len] = w;
		mem_u.len++;
		for (int i = 0; i < 20 && mem_u.idx < mem_u.len; i++) @(negedge core_clk);
		if ((w & OP_STORE_MASK) == OP_STORE_VAL) begin
			if (w[6:0] == OPTION_FADDR) m_opt = m_acc;
			if (w[6:0] == IRQCTL_FADDR) m_irq = m_acc;
			chk("store", fwr, {1'b1, w[6:0], m_acc[7:0]});
		end else chk("we", fwr.we, 0);
		if (w == OP_OPT_LOAD) m_opt = m_acc;
		if (w == OP_IRQ_RET) begin
			m_pc = stk.pop_back();
			m_irq[7] = 1;
		end else m_pc = (m_pc + 1) & 11'h7FF;
		chk("pc", pc, m_pc);
		chk("opt", opt, m_opt);
		chk("acc", acc, m_acc);
		chk("irq", irq, m_irq);
		chk("irq_en", irq_en, m_irq[7]);
		chk("rdy", instr_ready, w != OP_IRQ_RET);
	endtask : run
	task push(logic [10:0] a);
		// Caller lowers the strobe, so back-to-back pushes never toggle it
		stack_push = 1;
		push_addr = a;
		stk.push_back(a);
		@(negedge core_clk);
	endtask : push
	task rd_chk(logic [6:0] a, int exp);
		rd_addr = a;
		@(negedge core_clk);
		chk("rd", rd, exp);
	endtask : rd_chk
	initial begin
		repeat (12) @(negedge core_clk);
		rst_n = 1;
		chk("rst", {pc, opt, irq}, {11'h000, OPTION_RST, IRQCTL_RST});
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			acc_load = 1;
			acc_load_data = r[7:0];
			m_acc = r[7:0];
			@(negedge core_clk);
			acc_load = 0;
			run(14'h0080 | r[14:8]);
			run(14'(k << 5));
			run(k[0] ? OP_OPT_LOAD : 14'h0081);
		end
		r = rnd();
		ext_wr = '{1'b1, OPTION_FADDR, r[7:0]};
		@(negedge core_clk);
		ext_wr.we = 0;
		m_opt = r[7:0];
		chk("extopt", opt, m_opt);
		chk("echo", fwr, {1'b1, OPTION_FADDR, r[7:0]});
		rd_chk(OPTION_FADDR, m_opt);
		rd_chk(7'h55, 0);
		// Two nested returns, second right after the first
		push(r[18:8]);
		push(r[29:19]);
		stack_push = 0;
		irq_en_clear = 1;
		@(negedge core_clk);
		irq_en_clear = 0;
		m_irq[7] = 0;
		chk("en_clr", irq, m_irq);
		run(OP_IRQ_RET);
		run(OP_IRQ_RET);
		run(14'h0000);
		rd_chk(IRQCTL_FADDR, m_irq);
		wrap_up();
	end
endmodule : instr_decode_move_nop_interrupt_return_tb
